/* hw/phy_mode_pin_control.sv */
// PHY mode, strap and MII pin state control
// Function
// - Power-down pin high floats every MII pin, inputs included.
// - Each LED shows one status condition picked by its selector.
// - LED pins double as configuration strap inputs.
// - Straps sampled at power-up decide forced speed and duplex.
// - Without forcing, negotiate with partner through fast link pulse bursts.
// - Non-negotiating partner: link pulses give 10, idles give 100.
// - Hardware reset drives receive side low, clocks high, pulls transmit low.
// - Soft power-down and sleep drive receive low; sleep also lowers clocks.
// - Isolate floats all MII outputs with weak pull-downs on everything.
// - Half and full duplex at both 10 and 100 Mbps.
// - Reset from pin or control bit, stretched about 258 us after release.
// - Sleep pin enables sleep; managed override bit may replace it.
module phy_mode_pin_control #(
	parameter int RST_EXT_CYCLES = phy_mode_pkg::RST_EXT_CYCLES
) (
	input  wire logic                              I_CORE_CLK,         // Core clock, 125 MHz
	input  wire logic                              I_RST_N,            // Reset pin, active low
	input  wire logic                              I_SOFT_RESET,       // Control reset bit
	input  wire logic                              I_POWER_DOWN_PIN,   // Power-down pin
	input  wire logic                              I_SLEEP_PIN,        // Sleep enable pin
	input  wire logic                              I_SLEEP_OVR_EN,     // Managed override on
	input  wire logic                              I_SLEEP_OVR_VAL,    // Managed sleep value
	input  wire logic                              I_ISOLATE,          // Isolate control bit
	input  wire logic                              I_SOFT_POWER_DOWN,  // Soft power-down bit
	input  wire logic [phy_mode_pkg::CFG_PINS-1:0] I_LED_CFG,          // LED/strap pin levels
	input  wire logic [phy_mode_pkg::CFG_PINS-1:0][phy_mode_pkg::LED_SEL_W-1:0] I_LED_SEL, // LED selectors
	input  wire logic                              I_FLP_SEEN,         // Partner bursts seen
	input  wire logic [phy_mode_pkg::ABL_W-1:0]    I_PARTNER_ABL,      // Partner abilities
	input  wire logic                              I_NLP_SEEN,         // Partner link pulses
	input  wire logic                              I_IDLE_SEEN,        // Partner idle symbols
	input  wire logic                              I_LINK_FAIL,        // Line lost
	input  wire logic                              I_ACTIVITY,         // Frame activity
	input  wire phy_mode_pkg::mii_rx_t             I_MII_RX,           // Datapath receive bits
	input  wire logic                              I_MII_TX_CLK,       // Datapath transmit clock
	input  wire logic                              I_MII_RX_CLK,       // Datapath receive clock
	output phy_mode_pkg::mii_rx_t                  O_MII_RX,           // Receive side pin values
	output logic                                   O_MII_RX_OE_N,      // Receive side enable
	output logic                                   O_MII_RX_PD,        // Receive side pull-down
	output logic                                   O_TX_CLK,           // Transmit clock pin
	output logic                                   O_RX_CLK,           // Receive clock pin
	output logic                                   O_MII_CLK_OE_N,     // Clock pins enable
	output logic                                   O_MII_CLK_PD,       // Clock pins pull-down
	output logic                                   O_TX_IN_PD,         // Transmit input pull-down
	output logic                                   O_TX_IN_EN,         // Transmit input buffer on
	output logic [phy_mode_pkg::CFG_PINS-1:0]      O_LED,              // LED pin levels
	output logic [phy_mode_pkg::CFG_PINS-1:0]      O_LED_OE_N,         // LED pin enables
	output logic                                   O_INT_RESET,        // Stretched reset
	output phy_mode_pkg::pin_mode_t                O_MODE,             // Active pin mode
	output phy_mode_pkg::strap_t                   O_STRAP,            // Latched straps
	output logic                                   O_FLP_SEND,         // Send link bursts
	output logic                                   O_LINK_UP,          // Line up
	output logic                                   O_SPEED_100,        // 100 Mbps selected
	output logic                                   O_FULL_DUPLEX       // Full duplex selected
);

	localparam int RST_CNT_W = $clog2(RST_EXT_CYCLES + 1);
	localparam logic [RST_CNT_W-1:0] RST_LAST = RST_CNT_W'(RST_EXT_CYCLES - 1);

	typedef struct packed {
		logic                      in_reset;
		logic [RST_CNT_W-1:0]      rst_cnt;
		phy_mode_pkg::strap_t      strap;
		phy_mode_pkg::link_state_t link;
		phy_mode_pkg::line_cfg_t   line;
		phy_mode_pkg::pin_mode_t   mode;
		phy_mode_pkg::mii_rx_t     rx;
		logic                      rx_oe_n;
		logic                      rx_pd;
		logic                      tx_clk;
		logic                      rx_clk;
		logic                      clk_oe_n;
		logic                      clk_pd;
		logic                      tx_pd;
		logic                      tx_in_en;
	} ctl_t;

	// Reset look matches the hardware reset pin set
	localparam ctl_t CTL_RESET = '{
		in_reset: 1'b1, rst_cnt: '0, strap: '0, link: phy_mode_pkg::LS_RESET,
		line: '0, mode: phy_mode_pkg::MODE_HW_RESET, rx: '0, rx_oe_n: 1'b0,
		rx_pd: 1'b0, tx_clk: 1'b1, rx_clk: 1'b1, clk_oe_n: 1'b0, clk_pd: 1'b0,
		tx_pd: 1'b1, tx_in_en: 1'b1};

	ctl_t                                  r;
	ctl_t                                  next_r;
	logic                                  pd_sync;
	logic                                  sleep_sync;
	logic [phy_mode_pkg::CFG_PINS-1:0]     led_sync;
	logic                                  sleep_eff;
	logic [phy_mode_pkg::ABL_W-1:0]        common;
	phy_mode_pkg::line_cfg_t               resolved;
	phy_mode_pkg::led_status_t             status;

	// Pins cross into the core clock before use
	sync_two_flop #(.W(2)) u_ctl_sync (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_d     ({I_POWER_DOWN_PIN, I_SLEEP_PIN}),
		.o_q     ({pd_sync, sleep_sync})
	);

	sync_two_flop #(.W(phy_mode_pkg::CFG_PINS)) u_strap_sync (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_d     (I_LED_CFG),
		.o_q     (led_sync)
	);

	// Managed override replaces the sleep pin
	assign sleep_eff = I_SLEEP_OVR_EN ? I_SLEEP_OVR_VAL : sleep_sync;

	// Best common pair, 100 before 10, then full before half
	assign common = I_PARTNER_ABL & phy_mode_pkg::ABL_LOCAL;
	always_comb begin
		resolved = '0;
		if (common[phy_mode_pkg::ABL_100FD]) begin
			resolved = '{speed_100: 1'b1, full_duplex: 1'b1};
		end else if (common[phy_mode_pkg::ABL_100HD]) begin
			resolved = '{speed_100: 1'b1, full_duplex: 1'b0};
		end else if (common[phy_mode_pkg::ABL_10FD]) begin
			resolved = '{speed_100: 1'b0, full_duplex: 1'b1};
		end
	end

	always_comb begin
		next_r = r;
		// Reset stretch; control bit restarts it just like the pin
		if (I_SOFT_RESET) begin
			next_r.in_reset = 1'b1;
			next_r.rst_cnt  = '0;
		end else if (r.in_reset) begin
			if (r.rst_cnt == RST_LAST) begin
				next_r.in_reset = 1'b0;
			end else begin
				next_r.rst_cnt = r.rst_cnt + 1'b1;
			end
		end
		// Straps taken on the last stretched cycle, pins still released
		if (r.in_reset && !next_r.in_reset) begin
			next_r.strap = led_sync;
		end

		// Line bring-up
		case (r.link)
			phy_mode_pkg::LS_RESET: begin
				if (!r.in_reset) begin
					if (r.strap.an_enable) begin
						next_r.link = phy_mode_pkg::LS_NEGOTIATE;
					end else begin
						next_r.link = phy_mode_pkg::LS_LINKED;
						next_r.line = '{speed_100: r.strap.speed_100, full_duplex: r.strap.full_duplex};
					end
				end
			end
			phy_mode_pkg::LS_NEGOTIATE: begin
				if (I_FLP_SEEN && common != '0) begin
					next_r.link = phy_mode_pkg::LS_LINKED;
					next_r.line = resolved;
				end else if (I_IDLE_SEEN) begin
					// Parallel detection cannot learn duplex, so half
					next_r.link = phy_mode_pkg::LS_PARALLEL;
					next_r.line = '{speed_100: 1'b1, full_duplex: 1'b0};
				end else if (I_NLP_SEEN) begin
					next_r.link = phy_mode_pkg::LS_PARALLEL;
					next_r.line = '{speed_100: 1'b0, full_duplex: 1'b0};
				end
			end
			phy_mode_pkg::LS_LINKED,
			phy_mode_pkg::LS_PARALLEL: begin
				// Forced lines never fall back to negotiation
				if (I_LINK_FAIL && r.strap.an_enable) begin
					next_r.link = phy_mode_pkg::LS_NEGOTIATE;
				end
			end
			default: next_r.link = phy_mode_pkg::LS_RESET;
		endcase
		if (next_r.in_reset) begin
			next_r.link = phy_mode_pkg::LS_RESET;
		end

		// Mode precedence
		if (pd_sync) begin
			next_r.mode = phy_mode_pkg::MODE_HW_PD;
		end else if (next_r.in_reset) begin
			next_r.mode = phy_mode_pkg::MODE_HW_RESET;
		end else if (I_ISOLATE) begin
			next_r.mode = phy_mode_pkg::MODE_ISOLATE;
		end else if (I_SOFT_POWER_DOWN) begin
			next_r.mode = phy_mode_pkg::MODE_SOFT_PD;
		end else if (sleep_eff) begin
			next_r.mode = phy_mode_pkg::MODE_SLEEP;
		end else begin
			next_r.mode = phy_mode_pkg::MODE_NORMAL;
		end

		// Pin set for the chosen mode, defaults are normal running except the transmit pull-down, which normal clears
		next_r.rx       = I_MII_RX;
		next_r.rx_oe_n  = 1'b0;
		next_r.rx_pd    = 1'b0;
		next_r.tx_clk   = I_MII_TX_CLK;
		next_r.rx_clk   = I_MII_RX_CLK;
		next_r.clk_oe_n = 1'b0;
		next_r.clk_pd   = 1'b0;
		next_r.tx_pd    = 1'b1;
		next_r.tx_in_en = 1'b1;
		case (next_r.mode)
			phy_mode_pkg::MODE_HW_PD: begin
				// Nothing driven, nothing pulled, inputs cut off
				next_r.rx_oe_n  = 1'b1;
				next_r.clk_oe_n = 1'b1;
				next_r.tx_pd    = 1'b0;
				next_r.tx_in_en = 1'b0;
			end
			phy_mode_pkg::MODE_HW_RESET: begin
				next_r.rx     = '0;
				next_r.tx_clk = 1'b1;
				next_r.rx_clk = 1'b1;
			end
			phy_mode_pkg::MODE_ISOLATE: begin
				next_r.rx_oe_n  = 1'b1;
				next_r.rx_pd    = 1'b1;
				next_r.clk_oe_n = 1'b1;
				next_r.clk_pd   = 1'b1;
			end
			phy_mode_pkg::MODE_SOFT_PD: begin
				// Clocks keep running for the MAC
				next_r.rx = '0;
			end
			phy_mode_pkg::MODE_SLEEP: begin
				next_r.rx     = '0;
				next_r.tx_clk = 1'b0;
				next_r.rx_clk = 1'b0;
			end
			default: next_r.tx_pd = 1'b0;
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			r <= CTL_RESET;
		end else begin
			r <= next_r;
		end
	end

	// LED status from the live line state
	assign status = '{
		link:        (r.link == phy_mode_pkg::LS_LINKED) || (r.link == phy_mode_pkg::LS_PARALLEL),
		activity:    I_ACTIVITY,
		speed_100:   r.line.speed_100,
		full_duplex: r.line.full_duplex,
		collision:   I_MII_RX.col};

	for (genvar g = 0; g < phy_mode_pkg::CFG_PINS; g++) begin : g_led
		led_pin_cell u_led (
			.i_clk     (I_CORE_CLK),
			.i_rst_n   (I_RST_N),
			.i_sel     (I_LED_SEL[g]),
			.i_status  (status),
			.i_release (r.in_reset),
			.o_led     (O_LED[g]),
			.o_oe_n    (O_LED_OE_N[g])
		);
	end

	assign O_MII_RX       = r.rx;
	assign O_MII_RX_OE_N  = r.rx_oe_n;
	assign O_MII_RX_PD    = r.rx_pd;
	assign O_TX_CLK       = r.tx_clk;
	assign O_RX_CLK       = r.rx_clk;
	assign O_MII_CLK_OE_N = r.clk_oe_n;
	assign O_MII_CLK_PD   = r.clk_pd;
	assign O_TX_IN_PD     = r.tx_pd;
	assign O_TX_IN_EN     = r.tx_in_en;
	assign O_INT_RESET    = r.in_reset;
	assign O_MODE         = r.mode;
	assign O_STRAP        = r.strap;
	assign O_FLP_SEND     = (r.link == phy_mode_pkg::LS_NEGOTIATE);
	assign O_LINK_UP      = status.link;
	assign O_SPEED_100    = r.line.speed_100;
	assign O_FULL_DUPLEX  = r.line.full_duplex;

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_pd_held;
		I_POWER_DOWN_PIN [*3];
	endsequence

	a_hwpd_float: assert property (s_pd_held |=> O_MII_RX_OE_N && O_MII_CLK_OE_N && !O_TX_IN_EN && !O_TX_IN_PD)
		else $error("MII pins not floated in power-down");
	a_reset_pins: assert property (O_MODE == phy_mode_pkg::MODE_HW_RESET |->
		O_MII_RX == '0 && O_TX_CLK && O_RX_CLK && !O_MII_RX_OE_N && !O_MII_CLK_OE_N && O_TX_IN_PD)
		else $error("Wrong pin set in hardware reset");
	a_softpd_clocks: assert property (O_MODE == phy_mode_pkg::MODE_SOFT_PD |->
		O_TX_CLK == $past(I_MII_TX_CLK) && O_MII_RX == '0 && !O_MII_CLK_OE_N)
		else $error("Soft power-down clocks not live");
	a_sleep_pins: assert property (O_MODE == phy_mode_pkg::MODE_SLEEP |->
		!O_TX_CLK && !O_RX_CLK && O_MII_RX == '0 && !O_MII_RX_OE_N && O_TX_IN_PD)
		else $error("Wrong pin set in sleep");
	a_isolate_float: assert property (O_MODE == phy_mode_pkg::MODE_ISOLATE |->
		O_MII_RX_OE_N && O_MII_RX_PD && O_MII_CLK_OE_N && O_MII_CLK_PD && O_TX_IN_PD)
		else $error("Isolate pins not floated with pull-downs");
	a_reset_stretch: assert property ($fell(O_INT_RESET) |-> $past(r.rst_cnt) == RST_LAST)
		else $error("Reset stretch ended early");
	a_soft_reset: assert property (I_SOFT_RESET |=> O_INT_RESET && r.rst_cnt == '0)
		else $error("Control reset bit ignored");
	a_strap_latch: assert property ($fell(O_INT_RESET) |-> O_STRAP == $past(led_sync))
		else $error("Straps not taken at reset end");
	a_forced_line: assert property (r.link == phy_mode_pkg::LS_RESET && !O_INT_RESET && !O_STRAP.an_enable |=>
		O_LINK_UP && O_SPEED_100 == $past(O_STRAP.speed_100) && O_FULL_DUPLEX == $past(O_STRAP.full_duplex))
		else $error("Forced line settings not applied");
	a_neg_best: assert property (r.link == phy_mode_pkg::LS_NEGOTIATE && I_FLP_SEEN && !I_SOFT_RESET
		&& I_PARTNER_ABL[phy_mode_pkg::ABL_100FD] |=> r.link == phy_mode_pkg::LS_LINKED && O_SPEED_100 && O_FULL_DUPLEX)
		else $error("Negotiation did not pick 100 full");
	a_parallel_idle: assert property (r.link == phy_mode_pkg::LS_NEGOTIATE && !I_FLP_SEEN && I_IDLE_SEEN && !I_SOFT_RESET |=>
		r.link == phy_mode_pkg::LS_PARALLEL && O_SPEED_100 && !O_FULL_DUPLEX)
		else $error("Idle partner not set to 100 half");
	a_sleep_override: assert property (I_SLEEP_OVR_EN && I_SLEEP_OVR_VAL && !pd_sync && !I_ISOLATE && !I_SOFT_POWER_DOWN
		&& !O_INT_RESET && !I_SOFT_RESET |=> O_MODE == phy_mode_pkg::MODE_SLEEP)
		else $error("Sleep override not honoured");
	a_pd_priority: assert property (pd_sync |=> O_MODE == phy_mode_pkg::MODE_HW_PD)
		else $error("Power-down lost precedence");

endmodule // phy_mode_pin_control

/* hw/phy_mode_pkg.sv */
// Shared constants and types for the PHY mode and configuration pin control
package phy_mode_pkg;

	// Core clock and reset stretch timing
	localparam int CLK_PERIOD_NS  = 8;
	localparam int RST_EXT_US     = 258;
	// Least time, so rounded up to whole cycles
	localparam int RST_EXT_CYCLES = (RST_EXT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Configuration strap positions on the three shared LED pins
	localparam int CFG_PINS       = 3;
	localparam int CFG_AN_BIT     = 0;
	localparam int CFG_SPEED_BIT  = 1;
	localparam int CFG_DUPLEX_BIT = 2;

	// Partner ability vector positions
	localparam int ABL_W     = 4;
	localparam int ABL_10HD  = 0;
	localparam int ABL_10FD  = 1;
	localparam int ABL_100HD = 2;
	localparam int ABL_100FD = 3;
	// Local side offers every speed and duplex pair
	localparam logic [ABL_W-1:0] ABL_LOCAL = 4'hf;

	// LED condition selector codes
	localparam int                LED_SEL_W  = 3;
	localparam logic [LED_SEL_W-1:0] LED_LINK   = 3'h0;
	localparam logic [LED_SEL_W-1:0] LED_ACT    = 3'h1;
	localparam logic [LED_SEL_W-1:0] LED_SPEED  = 3'h2;
	localparam logic [LED_SEL_W-1:0] LED_DUPLEX = 3'h3;
	localparam logic [LED_SEL_W-1:0] LED_COL    = 3'h4;
	localparam logic [LED_SEL_W-1:0] LED_ON     = 3'h5;

	// MII pin set, listed by precedence
	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'h0,
		MODE_SLEEP    = 3'h1,
		MODE_SOFT_PD  = 3'h3,
		MODE_ISOLATE  = 3'h2,
		MODE_HW_RESET = 3'h6,
		MODE_HW_PD    = 3'h7
	} pin_mode_t;

	// Line bring-up state, Gray along reset, negotiate, linked
	typedef enum logic [1:0] {
		LS_RESET     = 2'h0,
		LS_NEGOTIATE = 2'h1,
		LS_LINKED    = 2'h3,
		LS_PARALLEL  = 2'h2
	} link_state_t;

	typedef struct packed {
		logic full_duplex;
		logic speed_100;
		logic an_enable;
	} strap_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
	} line_cfg_t;

	typedef struct packed {
		logic link;
		logic activity;
		logic speed_100;
		logic full_duplex;
		logic collision;
	} led_status_t;

	typedef struct packed {
		logic [3:0] rxd;
		logic       rx_dv;
		logic       rx_er;
		logic       col;
		logic       crs;
	} mii_rx_t;

endpackage

/* hw/sync_two_flop.sv */
// Two flip-flop synchroniser for pin levels
module sync_two_flop #(
	parameter int W = 1
) (
	input  wire logic         i_clk,   // Core clock
	input  wire logic         i_rst_n, // Async reset, active low
	input  wire logic [W-1:0] i_d,     // Asynchronous level
	output logic      [W-1:0] o_q      // Synchronised level
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_t;

	sync_t r;
	sync_t next_r;

	// First stage feeds only the second
	always_comb begin
		next_r.meta   = i_d;
		next_r.stable = r.meta;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_q = r.stable;

endmodule // sync_two_flop

/* hw/led_pin_cell.sv */
// One shared LED driver and configuration strap pin
module led_pin_cell (
	input  wire logic                                 i_clk,     // Core clock
	input  wire logic                                 i_rst_n,   // Async reset, active low
	input  wire logic [phy_mode_pkg::LED_SEL_W-1:0]   i_sel,     // Condition selector
	input  wire phy_mode_pkg::led_status_t            i_status,  // Line status
	input  wire logic                                 i_release, // Reset stretch active
	output logic                                      o_led,     // LED level, high lit
	output logic                                      o_oe_n     // Low while driving pin
);

	typedef struct packed {
		logic led;
		logic oe_n;
	} cell_t;

	cell_t r;
	cell_t next_r;
	logic  cond;

	// Condition pick; unused codes leave the LED dark
	always_comb begin
		case (i_sel)
			phy_mode_pkg::LED_LINK:   cond = i_status.link;
			phy_mode_pkg::LED_ACT:    cond = i_status.activity;
			phy_mode_pkg::LED_SPEED:  cond = i_status.speed_100;
			phy_mode_pkg::LED_DUPLEX: cond = i_status.full_duplex;
			phy_mode_pkg::LED_COL:    cond = i_status.collision;
			phy_mode_pkg::LED_ON:     cond = 1'b1;
			default:                  cond = 1'b0;
		endcase
	end

	// Pin released during reset so its strap can be read
	always_comb begin
		next_r.oe_n = i_release;
		next_r.led  = i_release ? 1'b0 : cond;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '{led: 1'b0, oe_n: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	assign o_led  = r.led;
	assign o_oe_n = r.oe_n;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	a_led_forced_on: assert property (i_sel == phy_mode_pkg::LED_ON && !i_release |=> o_led && !o_oe_n)
		else $error("LED not lit with always-on selection");
	a_led_released: assert property (i_release |=> o_oe_n && !o_led)
		else $error("LED pin driven during reset");

endmodule // led_pin_cell

/* verification/mac_mii_model.sv */
// MAC side of the MII: resolves receive and clock wires from drive, pull and float
module mac_mii_model (
	input  wire logic                   i_clk,      // Core clock
	input  wire phy_mode_pkg::mii_rx_t  i_rx,       // Receive pin values
	input  wire logic                   i_rx_oe_n,  // Receive enable, low drives
	input  wire logic                   i_rx_pd,    // Receive pull-down
	input  wire logic [1:0]             i_clk_val,  // Transmit and receive clock pins
	input  wire logic                   i_clk_oe_n, // Clock enable, low drives
	input  wire logic                   i_clk_pd,   // Clock pull-down
	output logic      [7:0]             o_rx_wire,  // Receive level seen by the MAC
	output logic      [1:0]             o_clk_wire  // Clock levels seen by the MAC
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_rx;
	logic [1:0] last_clk;

	// Remember the last resolved level so a bare float never looks like a stable value
	always @(posedge i_clk) begin
		last_rx <= o_rx_wire;
		last_clk <= o_clk_wire;
	end

	// Driven value wins, then pull-down, else inverse of last level
	always_comb begin
		o_rx_wire = !i_rx_oe_n ? i_rx : (i_rx_pd ? 8'h00 : ~last_rx);
		o_clk_wire = !i_clk_oe_n ? i_clk_val : (i_clk_pd ? 2'h0 : ~last_clk);
	end
endmodule // mac_mii_model

/* verification/testbench.sv */
// Self-checking bench for PHY mode, strap and MII pin control
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, soft_rst = 0, pd_pin = 0, slp = 0, oen = 0, oval = 0, iso = 0, spd = 0;
	logic fast_link_pulse_burst = 0, nlp = 0, idle = 0, lfail = 0, act = 1, o_link, o_spd, o_dup, o_fsend, o_ires;
	logic rx_oe_n, rx_pd, clk_oe_n, clk_pd, tx_pd, tx_en, tclk, rclk;
	logic [2:0] led_cfg = 3'h1, o_led, o_led_oe_n;
	logic [2:0][2:0] led_sel = '0;
	logic [3:0] abl = 4'h0;
	logic [7:0] rx_w;
	logic [1:0] clk_w;
	logic mtx = 1, mrx = 0;
	// Lit pattern per selector code with link 100 full, activity on, no collision
	localparam logic [7:0] LED_LIT = 8'h2f;
	logic [17:0] tab [6] = '{18'h00296, 18'h10c01, 18'h08400, 18'h06400, 18'h0c296, 18'h38800};
	phy_mode_pkg::mii_rx_t mii_rx = phy_mode_pkg::mii_rx_t'(8'ha5), o_rx;
	phy_mode_pkg::pin_mode_t o_mode;
	phy_mode_pkg::strap_t o_strap;
	int n_fail = 0, cmp_count = 0, cycles = 0;

	phy_mode_pin_control #(.RST_EXT_CYCLES(20)) i_dut (
		.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SOFT_RESET(soft_rst), .I_POWER_DOWN_PIN(pd_pin),
		.I_SLEEP_PIN(slp), .I_SLEEP_OVR_EN(oen), .I_SLEEP_OVR_VAL(oval), .I_ISOLATE(iso),
		.I_SOFT_POWER_DOWN(spd), .I_LED_CFG(led_cfg), .I_LED_SEL(led_sel), .I_FLP_SEEN(fast_link_pulse_burst),
		.I_PARTNER_ABL(abl), .I_NLP_SEEN(nlp), .I_IDLE_SEEN(idle), .I_LINK_FAIL(lfail),
		.I_ACTIVITY(act), .I_MII_RX(mii_rx), .I_MII_TX_CLK(mtx), .I_MII_RX_CLK(mrx),
		.O_MII_RX(o_rx), .O_MII_RX_OE_N(rx_oe_n), .O_MII_RX_PD(rx_pd), .O_TX_CLK(tclk),
		.O_RX_CLK(rclk), .O_MII_CLK_OE_N(clk_oe_n), .O_MII_CLK_PD(clk_pd), .O_TX_IN_PD(tx_pd),
		.O_TX_IN_EN(tx_en), .O_LED(o_led), .O_LED_OE_N(o_led_oe_n), .O_INT_RESET(o_ires),
		.O_MODE(o_mode), .O_STRAP(o_strap), .O_FLP_SEND(o_fsend), .O_LINK_UP(o_link),
		.O_SPEED_100(o_spd), .O_FULL_DUPLEX(o_dup));

	mac_mii_model i_mac (.i_clk(clk), .i_rx(o_rx), .i_rx_oe_n(rx_oe_n), .i_rx_pd(rx_pd),
		.i_clk_val({tclk, rclk}), .i_clk_oe_n(clk_oe_n), .i_clk_pd(clk_pd), .o_rx_wire(rx_w),
		.o_clk_wire(clk_w));

	// Reference clock stands in for the board oscillator
	initial begin
		forever #4 clk = ~clk;
	end

	// Hang guard, well above the planned run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t value %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Reset pin set: receive low, clocks high, transmit pulled, LEDs released
	task automatic chk_reset();
		chk(o_mode, phy_mode_pkg::MODE_HW_RESET);
		chk({rx_w, clk_w, tx_pd}, {8'h00, 2'h3, 1'b1});
		chk(o_led_oe_n, 3'h7);
	endtask

	// Drop the line, then offer one detector pattern to the negotiating state
	task automatic relink(input logic f, input logic [3:0] a, input logic i, input logic n, input logic [1:0] e);
		lfail = 1;
		{fast_link_pulse_burst, idle, nlp} = 3'h0;
		cyc(1);
		chk(o_fsend, 1'b1);
		lfail = 0;
		{fast_link_pulse_burst, abl, idle, nlp} = {f, a, i, n};
		cyc(1);
		chk({o_link, o_spd, o_dup}, {1'b1, e});
	endtask

	initial begin
		cyc(10);
		chk_reset();
		rst_n = 1;
		cyc(19);
		chk(o_ires, 1'b1);
		cyc(1);
		chk({o_ires, o_strap}, 4'h1);
		// Strap cycle: pins still released, driving starts one edge later
		chk(o_led_oe_n, 3'h7);
		cyc(1);
		chk(o_fsend, 1'b1);
		chk(o_led_oe_n, 3'h0);
		{fast_link_pulse_burst, abl} = 5'h18;
		cyc(1);
		chk({o_link, o_spd, o_dup}, 3'h7);
		done("negotiation");
		// Every selector code, lit pattern worked out from link 100 full, activity on
		for (int s = 0; s < 8; s++) begin
			led_sel = {3{s[2:0]}};
			cyc(1);
			chk(o_led, {3{LED_LIT[s]}});
		end
		done("leds");
		relink(1'b1, 4'h2, 1'b0, 1'b0, 2'h1);
		relink(1'b0, 4'h0, 1'b1, 1'b0, 2'h2);
		relink(1'b0, 4'h0, 1'b0, 1'b1, 2'h0);
		done("parallel detect");
		for (int k = 0; k < 6; k++) begin
			{iso, spd, slp, oen, oval} = tab[k][17:13];
			// Clock inputs flip between entries so live clocks are really seen
			{mtx, mrx} = k[0] ? 2'h1 : 2'h2;
			cyc(4);
			chk(o_mode, tab[k][12:10]);
			chk({rx_w, clk_w}, tab[k][9:0]);
			chk({tx_pd, rx_oe_n, clk_oe_n}, {tab[k][12:10] != 3'h0, {2{tab[k][12:10] == 3'h2}}});
		end
		done("pin modes");
		pd_pin = 1;
		cyc(4);
		chk({o_mode, rx_oe_n, clk_oe_n, rx_pd, clk_pd, tx_en}, 8'hf8);
		rst_n = 0;
		pd_pin = 0;
		{iso, spd, slp, oen, oval} = 5'h00;
		cyc(4);
		chk_reset();
		// Power-down raised across the stretch must still win over it
		led_cfg = 3'h6;
		pd_pin = 1;
		rst_n = 1;
		cyc(3);
		chk({o_ires, o_mode}, 4'hf);
		pd_pin = 0;
		cyc(17);
		chk(o_strap, 3'h6);
		cyc(1);
		chk({o_link, o_spd, o_dup, o_fsend}, 4'he);
		done("power down and forced");
		soft_rst = 1;
		cyc(2);
		chk({o_ires, o_mode}, 4'he);
		soft_rst = 0;
		cyc(19);
		chk(o_ires, 1'b1);
		cyc(1);
		chk(o_ires, 1'b0);
		done("soft reset");
		report_and_stop();
	end
endmodule // testbench
